// file: rtl/rcam_consts.svh
// Constants for the receive CRC, align and monitor control register.
// How it works
// - Bit 7 selects the receive CRC6 checker, 0 for the standard variant and 1 for the Japanese one.
// - A rising edge of bit 6 sends one align command to the receive elastic store.
// - A rising edge of bit 5 sends one align command to the transmit elastic store.
// - A store whose pointer separation is already half a frame or more ignores the command.
// - A store closer than half a frame realigns and flags its data as corrupted meanwhile.
// - A bit held at one gives no further command; software must clear and set it again.
// - Bits 4 down to 0 select which receive channel is copied into the monitor register.
// - The register answers at byte address 0x1E.
`ifndef RCAM_CONSTS_SVH
`define RCAM_CONSTS_SVH
`define RCAM_ADDR        8'h1E
`define RCAM_RESET       8'h00
`define RCAM_BIT_CRC     7
`define RCAM_BIT_RXALGN  6
`define RCAM_BIT_TXALGN  5
`define RCAM_CHAN_MSB    4
`define RCAM_CHAN_LSB    0
`define RCAM_CORRUPT_CYC 4'h8
`define RCAM_CNT_ZERO    4'h0
`define RCAM_CNT_STEP    4'h1
`define RCAM_RD_IDLE     8'h00
`define RCAM_DIRS        2
`define RCAM_DIR_RX      0
`define RCAM_DIR_TX      1
`endif

// file: rtl/rcam_pkg.sv
// Types for the receive CRC, align and monitor control register.
package rcam_pkg;
    typedef struct packed {
        logic       rx_crc_variant_select;
        logic       rx_buffer_align_cmd;
        logic       tx_buffer_align_cmd;
        logic [4:0] rx_monitor_chan_sel;
    } rcam_reg_t;

    typedef struct packed {
        rcam_reg_t  ctrl;
        logic [7:0] rd_data;
        logic       rx_align_pulse;
        logic       tx_align_pulse;
        logic [3:0] rx_corrupt_cnt;
        logic [3:0] tx_corrupt_cnt;
        logic       rx_corrupt;
        logic       tx_corrupt;
    } rcam_state_t;
endpackage

// file: rtl/rcam_ctrl.sv
// Receive CRC variant, elastic store align and channel monitor control register.
`include "rcam_consts.svh"
module rcam_ctrl (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // Processor port
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] wr_data_i,
    output logic      [7:0] rd_data_o,
    // Elastic store pointer status, same clock domain
    input  wire logic       rx_sep_half_i,
    input  wire logic       tx_sep_half_i,
    // Controls
    output logic            rx_crc_variant_select_o,
    output logic [4:0]      rx_monitor_chan_sel_o,
    output logic            rx_align_pulse_o,
    output logic            tx_align_pulse_o,
    output logic            rx_corrupt_o,
    output logic            tx_corrupt_o
);

    // ========================================
    // Overview
    // The register holds one byte of control for one framer channel.
    // Bit 7 and bits 4 down to 0 are plain levels that the receive CRC
    // checker and the channel monitor read all the time.
    // Bits 6 and 5 are stored as levels as well, but what the elastic
    // stores act on is the one-cycle pulse made when a write turns a
    // stored zero into a one.
    // The stores themselves decide from their live pointer separation
    // whether the command does anything; this block only mirrors that
    // decision in a fixed window that tells the data path to distrust
    // the bytes passing the store while it realigns.
    // The window length is a fixed count of this clock, not a measured
    // frame time, so a user who needs the exact length of the disruption
    // must take it from the store and not from this flag.

    // ========================================
    // State and decode wires
    rcam_pkg::rcam_state_t st;
    rcam_pkg::rcam_state_t next_st;
    rcam_pkg::rcam_reg_t   wr_ctrl;
    logic                  hit;
    logic                  wr_hit;
    logic                  rd_hit;
    logic                  rd_miss;
    logic                  rx_cmd_bit;
    logic                  tx_cmd_bit;

    // Per-direction view of the two realignment windows.
    logic [`RCAM_DIRS-1:0] sep_half;
    logic [`RCAM_DIRS-1:0] pulse_now;
    logic [`RCAM_DIRS-1:0] win_start;
    logic [3:0]            cur_cnt  [`RCAM_DIRS];
    logic [3:0]            next_cnt [`RCAM_DIRS];

    // ========================================
    // Decode functions
    // The one address compare serves both the write and the read path.
    function automatic logic addr_match(
        input logic [7:0] addr
    );
        addr_match = (addr == `RCAM_ADDR);
    endfunction

    // A one written over a stored zero is a command; a one written over a
    // stored one is the held level and stays silent, so software has to
    // clear the bit before it can ask for the next alignment.
    function automatic logic rising_cmd(
        input logic written,
        input logic stored
    );
        rising_cmd = written && !stored;
    endfunction

    // The write byte is split into fields by name, so that a change of
    // field order in the package cannot move a bit silently.
    function automatic rcam_pkg::rcam_reg_t byte_to_ctrl(
        input logic [7:0] data
    );
        rcam_pkg::rcam_reg_t ctrl;
        ctrl.rx_crc_variant_select = data[`RCAM_BIT_CRC];
        ctrl.rx_buffer_align_cmd   = data[`RCAM_BIT_RXALGN];
        ctrl.tx_buffer_align_cmd   = data[`RCAM_BIT_TXALGN];
        ctrl.rx_monitor_chan_sel   = data[`RCAM_CHAN_MSB:`RCAM_CHAN_LSB];
        byte_to_ctrl = ctrl;
    endfunction

    // The read byte is built back from the same field positions.
    function automatic logic [7:0] ctrl_to_byte(
        input rcam_pkg::rcam_reg_t ctrl
    );
        logic [7:0] data;
        data                                = `RCAM_RD_IDLE;
        data[`RCAM_BIT_CRC]                 = ctrl.rx_crc_variant_select;
        data[`RCAM_BIT_RXALGN]              = ctrl.rx_buffer_align_cmd;
        data[`RCAM_BIT_TXALGN]              = ctrl.tx_buffer_align_cmd;
        data[`RCAM_CHAN_MSB:`RCAM_CHAN_LSB] = ctrl.rx_monitor_chan_sel;
        ctrl_to_byte = data;
    endfunction

    // One step of a realignment window: load on a start, count down to
    // zero otherwise, and rest at zero.
    function automatic logic [3:0] window_step(
        input logic       start,
        input logic [3:0] count
    );
        if (start) begin
            window_step = `RCAM_CORRUPT_CYC;
        end else if (count != `RCAM_CNT_ZERO) begin
            window_step = count - `RCAM_CNT_STEP;
        end else begin
            window_step = `RCAM_CNT_ZERO;
        end
    endfunction

    // ========================================
    // Decode
    assign hit        = addr_match(addr_i);
    assign wr_hit     = wr_en_i && hit;
    assign rd_hit     = rd_en_i && hit;
    assign rd_miss    = rd_en_i && !hit;
    assign wr_ctrl    = byte_to_ctrl(wr_data_i);
    assign rx_cmd_bit = wr_ctrl.rx_buffer_align_cmd;
    assign tx_cmd_bit = wr_ctrl.tx_buffer_align_cmd;

    // ========================================
    // Realignment windows
    // The store reports its live separation; the window opens only when it
    // is short, since a store already half a frame apart ignores the command.
    assign sep_half[`RCAM_DIR_RX]  = rx_sep_half_i;
    assign sep_half[`RCAM_DIR_TX]  = tx_sep_half_i;
    assign pulse_now[`RCAM_DIR_RX] = st.rx_align_pulse;
    assign pulse_now[`RCAM_DIR_TX] = st.tx_align_pulse;
    assign cur_cnt[`RCAM_DIR_RX]   = st.rx_corrupt_cnt;
    assign cur_cnt[`RCAM_DIR_TX]   = st.tx_corrupt_cnt;

    generate
        for (genvar d = 0; d < `RCAM_DIRS; d++) begin : g_dir
            assign win_start[d] = pulse_now[d] && !sep_half[d];
            assign next_cnt[d]  = window_step(win_start[d], cur_cnt[d]);
        end
    endgenerate

    // ========================================
    // Next state
    always_comb begin
        next_st = st;

        // Align pulses last one cycle unless a fresh edge is written.
        next_st.rx_align_pulse = 1'b0;
        next_st.tx_align_pulse = 1'b0;

        // Write path.
        if (wr_hit) begin
            next_st.ctrl           = wr_ctrl;
            next_st.rx_align_pulse = rising_cmd(rx_cmd_bit,
                                                st.ctrl.rx_buffer_align_cmd);
            next_st.tx_align_pulse = rising_cmd(tx_cmd_bit,
                                                st.ctrl.tx_buffer_align_cmd);
        end

        // Read path: a read of another address returns zero, so that a stale
        // byte of this register is never mistaken for a neighbour's.
        if (rd_hit) begin
            next_st.rd_data = ctrl_to_byte(st.ctrl);
        end else if (rd_miss) begin
            next_st.rd_data = `RCAM_RD_IDLE;
        end

        // Realignment windows.
        next_st.rx_corrupt_cnt = next_cnt[`RCAM_DIR_RX];
        next_st.tx_corrupt_cnt = next_cnt[`RCAM_DIR_TX];
        next_st.rx_corrupt     = (next_cnt[`RCAM_DIR_RX] != `RCAM_CNT_ZERO);
        next_st.tx_corrupt     = (next_cnt[`RCAM_DIR_TX] != `RCAM_CNT_ZERO);
    end

    // ========================================
    // State register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st      <= '0;
            st.ctrl <= rcam_pkg::rcam_reg_t'(`RCAM_RESET);
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // Outputs straight from the state flip-flops
    // Read data.
    assign rd_data_o               = st.rd_data;

    // Plain control levels.
    assign rx_crc_variant_select_o = st.ctrl.rx_crc_variant_select;
    assign rx_monitor_chan_sel_o   = st.ctrl.rx_monitor_chan_sel;

    // The pulse only reaches the store; it alone decides, from its live separation.
    assign rx_align_pulse_o        = st.rx_align_pulse;
    assign tx_align_pulse_o        = st.tx_align_pulse;

    // Realignment windows.
    assign rx_corrupt_o            = st.rx_corrupt;
    assign tx_corrupt_o            = st.tx_corrupt;

endmodule // rcam_ctrl

// file: verification/rcam_ctrl_chk.sv
// Checker that ties the control register outputs to its processor port.
module rcam_chk (
    input wire logic       ref_clk_i, sys_rst_i, wr_en_i, rd_en_i, rx_sep_half_i, tx_sep_half_i,
    input wire logic [7:0] addr_i, wr_data_i, rd_data_o,
    input wire logic [4:0] rx_monitor_chan_sel_o,
    input wire logic       rx_crc_variant_select_o, rx_align_pulse_o, tx_align_pulse_o,
    input wire logic       rx_corrupt_o, tx_corrupt_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire wr = wr_en_i && addr_i == 8'h1E;
    crc_sel_a: assert property (wr |=> rx_crc_variant_select_o == $past(wr_data_i[7]))
        else $error("crc select");
    rx_pulse_a: assert property (rx_align_pulse_o |-> $past(wr && wr_data_i[6]))
        else $error("rx pulse");
    tx_pulse_a: assert property (tx_align_pulse_o |-> $past(wr && wr_data_i[5]))
        else $error("tx pulse");
    rx_keep_a: assert property (rx_align_pulse_o && rx_sep_half_i && !rx_corrupt_o |=> !rx_corrupt_o)
        else $error("rx keep");
    rx_fix_a: assert property (rx_align_pulse_o && !rx_sep_half_i && !rx_corrupt_o
        |=> rx_corrupt_o[*8] ##1 !rx_corrupt_o) else $error("rx realign");
    tx_fix_a: assert property (tx_align_pulse_o && !tx_sep_half_i && !tx_corrupt_o
        |=> tx_corrupt_o[*8] ##1 !tx_corrupt_o) else $error("tx realign");
    pulse_once_a: assert property (rx_align_pulse_o |=> !rx_align_pulse_o)
        else $error("pulse length");
    chan_sel_a: assert property (wr |=> rx_monitor_chan_sel_o == $past(wr_data_i[4:0]))
        else $error("channel select");
    addr_dec_a: assert property (wr_en_i && addr_i != 8'h1E |=> $stable(rx_monitor_chan_sel_o))
        else $error("address decode");
endmodule // rcam_chk
bind rcam_ctrl rcam_chk chk_i (.*);

// file: verification/rcam_ctrl_bench.sv
// Self-checking bench for the control register.
module rcam_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, rst = 1, we = 0, re = 0, rs = 0, ts = 0, cv, rp, tp, rc, tc;
    logic [7:0] ad = 0, wd = 0, rdo;
    logic [4:0] cs;
    int         n_errors = 0, comparisons = 0, cyc = 0;
    rcam_ctrl dut (.ref_clk_i(clk), .sys_rst_i(rst), .addr_i(ad), .wr_en_i(we), .rd_en_i(re),
        .wr_data_i(wd), .rd_data_o(rdo), .rx_sep_half_i(rs), .tx_sep_half_i(ts),
        .rx_crc_variant_select_o(cv), .rx_monitor_chan_sel_o(cs), .rx_align_pulse_o(rp),
        .tx_align_pulse_o(tp), .rx_corrupt_o(rc), .tx_corrupt_o(tc));
    always #10 clk = ~clk;
    always @(posedge clk) if (++cyc > 500) begin n_errors++; tally_and_finish(); end
    task automatic chk(logic [7:0] g, e);
        comparisons++;
        if (g !== e) begin n_errors++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end
    endtask
    // One access; on return the registered answer of that access is visible.
    task automatic acc(logic w, logic [7:0] a, d);
        @(posedge clk) #2 {we, re, ad, wd} = {w, !w, a, d};
        @(posedge clk) #2 {we, re} = 2'b00;
    endtask
    task automatic t_regs;
        acc(1, 8'h1E, 8'h9F);
        chk({cv, 2'b00, cs}, 8'h9F);
        acc(1, 8'h1F, 8'h00);
        acc(0, 8'h1E, 8'h00);
        chk(rdo, 8'h9F);
        acc(0, 8'h1F, 8'h00);
        chk(rdo, 8'h00);
        $display("register test done");
    endtask
    task automatic t_align;
        acc(1, 8'h1E, 8'h40);
        chk(8'({rp, tp}), 8'h02);
        @(posedge clk) #2 chk(8'(rc), 8'h01);
        repeat (8) @(posedge clk);
        #2 chk(8'(rc), 8'h00);
        rs = 1;
        acc(1, 8'h1E, 8'h00);
        acc(1, 8'h1E, 8'h60);
        chk(8'({rp, tp}), 8'h03);
        @(posedge clk) #2 chk(8'({rc, tc}), 8'h01);
        acc(1, 8'h1E, 8'h60);
        chk(8'({rp, tp}), 8'h00);
        acc(0, 8'h1E, 8'h00);
        chk(rdo, 8'h60);
        $display("align test done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #2 rst = 0;
        t_regs();
        t_align();
        tally_and_finish();
    end
endmodule // rcam_ctrl_bench
